// *** rtl/sese_pkg.sv ***
// Package for the secondary error severity register logic
package sese_pkg;

    localparam int          CLS_W          = 14;
    localparam int          PTR_W          = 5;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;

    // Register offsets in the extended configuration space
    localparam logic [11:0] SEV_OFFSET     = 12'h134;
    localparam logic [11:0] CAPS_OFFSET    = 12'h138;

    // Severity register layout
    localparam logic [31:0] SEV_RESET      = 32'h0000_1340;
    localparam logic [31:0] SEV_RW_MASK    = 32'h0000_3FEE;
    localparam logic [13:0] IMPL_CLASSES   = 14'h1E8C;
    localparam logic [31:0] CAPS_RESET     = 32'h0000_0000;
    localparam logic [4:0]  PTR_RESET      = 5'h00;

    // Field positions of the severity register
    localparam int          INTERNAL_FAULT_SEVERITY_BIT        = 13;
    localparam int          SYSTEM_ERROR_SEEN_SEVERITY_BIT     = 12;
    localparam int          PARITY_SIGNAL_SEEN_SEVERITY_BIT    = 11;
    localparam int          DELAYED_DISCARD_EXPIRY_SEVERITY_BIT = 10;
    localparam int          ADDRESS_PARITY_FAULT_SEVERITY_BIT  = 9;
    localparam int          ATTRIBUTE_FAULT_SEVERITY_BIT       = 8;
    localparam int          DATA_PARITY_FAULT_SEVERITY_BIT     = 7;
    localparam int          SPLIT_MESSAGE_DATA_SEVERITY_BIT    = 6;
    localparam int          UNEXPECTED_SPLIT_SEVERITY_BIT      = 5;
    localparam int          INITIATOR_ABORT_SEVERITY_BIT       = 3;
    localparam int          RESPONDER_ABORT_SEVERITY_BIT       = 2;
    localparam int          SPLIT_INITIATOR_ABORT_SEVERITY_BIT = 1;

    typedef struct packed {
        logic [31:0] severity;
        logic [4:0]  first_fault_pointer;
        logic        msg_fatal;
        logic        msg_nonfatal;
        logic [31:0] rdata;
        logic        rvalid;
    } sese_state_t;

endpackage : sese_pkg

// *** rtl/sese_class_route.sv ***
// One error class: mask gate and severity routing to message requests
`timescale 1ns/1ps
module sese_class_route #(
    parameter bit IMPLEMENTED = 1'b1
) (
    input  wire logic detect,
    input  wire logic masked,
    input  wire logic severity,
    output logic      fatal_req,
    output logic      nonfatal_req
);
    // Unsupported classes never reach the message path
    assign fatal_req    = IMPLEMENTED && detect && !masked && severity;
    assign nonfatal_req = IMPLEMENTED && detect && !masked && !severity;
endmodule : sese_class_route

// *** rtl/sese_regs.sv ***
// Secondary error severity and capabilities registers with message routing
//
// Function
// - A detected supported error is reported fatal when its severity bit is 1, else nonfatal.
// - Severity bits 12 and 9 are read/write and reset to 1.
// - Severity bits 11, 10, 7, 3 and 2 are read/write and reset to 0.
// - Severity bits 13, 8, 6, 5 and 1 are plain storage with no effect on reporting.
// - Severity bits 31:14, 4 and 0 read zero, giving a reset value of 0x00001340.
// - The capabilities register is read-only, resets to zero, and bits 31:5 read zero.
// - The pointer in bits 4:0 takes the status bit position of the first error detected.
// - A masked class gives no message and leaves the pointer unchanged.
`timescale 1ns/1ps
module sese_regs
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         cfg_wr,
    input  wire logic                         cfg_rd,
    input  wire logic [sese_pkg::ADDR_W-1:0]  cfg_addr,
    input  wire logic [sese_pkg::DATA_W-1:0]  cfg_wdata,
    input  wire logic [3:0]                   cfg_be,
    output logic      [sese_pkg::DATA_W-1:0]  cfg_rdata,
    output logic                              cfg_rvalid,
    input  wire logic [sese_pkg::CLS_W-1:0]   err_detect,
    input  wire logic [sese_pkg::CLS_W-1:0]   err_mask,
    input  wire logic [sese_pkg::CLS_W-1:0]   err_status,
    output logic                              msg_fatal,
    output logic                              msg_nonfatal,
    output logic      [sese_pkg::PTR_W-1:0]   first_fault_pointer
);
    import sese_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    sese_state_t             st;
    sese_state_t             next_st;
    logic [CLS_W-1:0]        fatal_req;
    logic [CLS_W-1:0]        nonfatal_req;
    logic [CLS_W-1:0]        hit;
    logic                    any_hit;
    logic [PTR_W-1:0]        first_idx;
    logic [31:0]             wmask;
    logic                    ptr_free;

    for (genvar i = 0; i < CLS_W; i++)
    begin : g_cls
        sese_class_route #(
            .IMPLEMENTED (IMPL_CLASSES[i])
        ) u_route (
            .detect       (err_detect[i]),
            .masked       (err_mask[i]),
            .severity     (st.severity[i]),
            .fatal_req    (fatal_req[i]),
            .nonfatal_req (nonfatal_req[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign hit      = fatal_req | nonfatal_req;
    assign any_hit  = |hit;
    // Pointer may only move once software has cleared the bit it names
    assign ptr_free = !err_status[st.first_fault_pointer[3:0]] ||
                      (st.first_fault_pointer > 5'(CLS_W - 1));
    assign wmask    = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}}
                      & SEV_RW_MASK;

    always_comb
    begin
        // Lowest bit position wins when several classes fire together
        first_idx            = PTR_RESET;
        for (int i = CLS_W - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                first_idx = PTR_W'(i);
            end
        end
        next_st              = st;
        next_st.msg_fatal    = |fatal_req;
        next_st.msg_nonfatal = |nonfatal_req;
        next_st.rvalid       = cfg_rd;
        next_st.rdata        = 32'h0000_0000;
        if (cfg_wr && (cfg_addr == SEV_OFFSET))
        begin
            // Unsupported class bits are kept but feed nothing
            next_st.severity = (st.severity & ~wmask) | (cfg_wdata & wmask);
        end
        if (any_hit && ptr_free)
        begin
            next_st.first_fault_pointer = first_idx;
        end
        if (cfg_rd)
        begin
            case (cfg_addr)
                SEV_OFFSET:  next_st.rdata = st.severity & SEV_RW_MASK;
                CAPS_OFFSET: next_st.rdata = {27'h0, st.first_fault_pointer};
                default:     next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st.severity            <= SEV_RESET;
            st.first_fault_pointer <= PTR_RESET;
            st.msg_fatal           <= 1'b0;
            st.msg_nonfatal        <= 1'b0;
            st.rdata               <= CAPS_RESET;
            st.rvalid              <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cfg_rdata           = st.rdata;
    assign cfg_rvalid          = st.rvalid;
    assign msg_fatal           = st.msg_fatal;
    assign msg_nonfatal        = st.msg_nonfatal;
    assign first_fault_pointer = st.first_fault_pointer;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_fatal_hit;
        |(err_detect & ~err_mask & IMPL_CLASSES & st.severity[13:0]);
    endsequence

    sequence s_nonfatal_hit;
        |(err_detect & ~err_mask & IMPL_CLASSES & ~st.severity[13:0]);
    endsequence

    sequence s_read_caps;
        cfg_rd && (cfg_addr == CAPS_OFFSET);
    endsequence

    property p_fatal_msg;
        @(posedge clk) disable iff (rst)
        s_fatal_hit |=> msg_fatal;
    endproperty
    a_fatal_msg: assert property (p_fatal_msg)
        else $error("fatal message missing");

    property p_nonfatal_msg;
        @(posedge clk) disable iff (rst)
        s_nonfatal_hit |=> msg_nonfatal;
    endproperty
    a_nonfatal_msg: assert property (p_nonfatal_msg)
        else $error("nonfatal message missing");

    property p_reset_fatal_default;
        @(posedge clk)
        $fell(rst) |-> (st.severity[12] && st.severity[9]);
    endproperty
    a_reset_fatal_default: assert property (p_reset_fatal_default)
        else $error("fatal default lost");

    property p_reset_nonfatal_default;
        @(posedge clk)
        $fell(rst) |-> ((st.severity & 32'h0000_0C8C) == 32'h0000_0000);
    endproperty
    a_reset_nonfatal_default: assert property (p_reset_nonfatal_default)
        else $error("nonfatal default lost");

    property p_unsupported_silent;
        @(posedge clk) disable iff (rst)
        ((err_detect & IMPL_CLASSES) == 14'h0000) |=> !msg_fatal && !msg_nonfatal;
    endproperty
    a_unsupported_silent: assert property (p_unsupported_silent)
        else $error("unsupported class reported");

    // Full-word write lands on the writable bits only
    property p_sev_write;
        @(posedge clk) disable iff (rst)
        cfg_wr && (cfg_addr == SEV_OFFSET) && (cfg_be == 4'hF)
            |=> (st.severity == ($past(cfg_wdata) & SEV_RW_MASK));
    endproperty
    a_sev_write: assert property (p_sev_write)
        else $error("severity write lost");

    property p_sev_reserved_zero;
        @(posedge clk) disable iff (rst)
        cfg_rd && (cfg_addr == SEV_OFFSET) |=> cfg_rvalid && ((cfg_rdata & ~SEV_RW_MASK) == 32'h0);
    endproperty
    a_sev_reserved_zero: assert property (p_sev_reserved_zero)
        else $error("reserved severity bits set");

    property p_caps_upper_zero;
        @(posedge clk) disable iff (rst)
        s_read_caps |=> cfg_rvalid && (cfg_rdata[31:5] == 27'h0)
            && (cfg_rdata[4:0] == $past(st.first_fault_pointer));
    endproperty
    a_caps_upper_zero: assert property (p_caps_upper_zero)
        else $error("capabilities readback wrong");

    // A write to the read-only register must not disturb the pointer
    property p_caps_no_write;
        @(posedge clk) disable iff (rst)
        cfg_wr && (cfg_addr == CAPS_OFFSET) && !any_hit |=> $stable(first_fault_pointer);
    endproperty
    a_caps_no_write: assert property (p_caps_no_write)
        else $error("capabilities register took a write");

    property p_ptr_load;
        @(posedge clk) disable iff (rst)
        (any_hit && ptr_free) |=> (first_fault_pointer == $past(first_idx));
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer not loaded");

    // Loaded pointer names a class that fired, and no lower one fired
    property p_ptr_lowest;
        @(posedge clk) disable iff (rst)
        (any_hit && ptr_free)
            |=> ((($past(hit) >> first_fault_pointer) & 14'h0001) == 14'h0001)
            && (($past(hit) & ((14'h0001 << first_fault_pointer) - 14'h0001)) == 14'h0000);
    endproperty
    a_ptr_lowest: assert property (p_ptr_lowest)
        else $error("pointer not lowest hit");

    property p_masked_quiet;
        @(posedge clk) disable iff (rst)
        ((err_detect & ~err_mask) == 14'h0000)
            |=> !msg_fatal && !msg_nonfatal && $stable(first_fault_pointer);
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("masked class had effect");

    property p_ptr_hold;
        @(posedge clk) disable iff (rst)
        !ptr_free |=> $stable(first_fault_pointer);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold)
        else $error("pointer moved while status set");

endmodule : sese_regs

// *** dv/sese_msg_sink.sv ***
// Upstream port model that counts the error messages from the bridge
`timescale 1ns/1ps
module sese_msg_sink (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic msg_fatal,
    input  wire logic msg_nonfatal,
    output int        n_fatal,
    output int        n_nonfatal
);
    ////////////////////////////////////////////////////////////////////////////////
    // Accepts a message every cycle; each cycle a request is high counts as one message
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            n_fatal    <= 0;
            n_nonfatal <= 0;
        end
        else
        begin
            n_fatal    <= n_fatal + int'(msg_fatal === 1'b1);
            n_nonfatal <= n_nonfatal + int'(msg_nonfatal === 1'b1);
        end
    end
endmodule : sese_msg_sink

// *** dv/sese_regs_tb.sv ***
// Self-checking bench for the secondary error severity registers
`timescale 1ns/1ps
module sese_regs_tb;
    import sese_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [11:0] cfg_addr = 12'h000;
    logic [31:0] cfg_wdata = 32'h0;
    logic [3:0]  cfg_be = 4'hF;
    logic [31:0] cfg_rdata;
    logic        cfg_rvalid;
    logic        msg_fatal;
    logic        msg_nonfatal;
    logic [13:0] err_detect = 14'h0;
    logic [13:0] err_mask = 14'h0;
    logic [13:0] err_status = 14'h0;
    logic [4:0]  first_fault_pointer;
    logic [4:0]  ptr = 5'h00;
    logic [31:0] sev = SEV_RESET;
    logic [31:0] lfsr = 32'h78782AEC;
    logic [33:0] exp_q[$];
    logic [33:0] obs;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_f = 0;
    int          n_nf = 0;
    int          n_fatal;
    int          n_nonfatal;

    sese_regs sese_regs_inst (.clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be,
        .cfg_rdata, .cfg_rvalid, .err_detect, .err_mask, .err_status, .msg_fatal,
        .msg_nonfatal, .first_fault_pointer);
    sese_msg_sink sese_msg_sink_inst (.clk, .rst, .msg_fatal, .msg_nonfatal, .n_fatal,
        .n_nonfatal);

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    task automatic check(input logic [33:0] got, input logic [33:0] want);
        n_checks++;
        if (got !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // One request cycle; strobes drop at the next falling edge
    task automatic cyc(input logic w, r, input logic [11:0] a, input logic [31:0] d,
                       input logic [13:0] det, msk, st);
        @(negedge clk);
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, r, a, d};
        {err_detect, err_mask, err_status} = {det, msk, st};
        @(negedge clk);
        {cfg_wr, cfg_rd, err_detect} = '0;
    endtask : cyc

    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        exp_q.push_back({2'b00, want});
        cyc(1'b0, 1'b1, a, 32'h0, 14'h0, err_mask, err_status);
    endtask : rd

    // Model follows the byte enables; only writable severity bits change
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] m;
        m = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}} & 32'h0000_3FEE;
        if (a == SEV_OFFSET)
            sev = (sev & ~m) | (d & m);
        cyc(1'b1, 1'b0, a, d, 14'h0, err_mask, err_status);
    endtask : wr

    // Pointer takes the lowest hit only while the status it names is clear
    task automatic hit(input logic [13:0] det, msk, st);
        logic [13:0] live;
        logic        f;
        logic        nf;
        live = det & ~msk & IMPL_CLASSES;
        f = |(live & sev[13:0]);
        nf = |(live & ~sev[13:0]);
        if (live != 0 && (ptr > 13 || !st[ptr]))
            for (int i = 13; i >= 0; i--)
                if (live[i])
                    ptr = 5'(i);
        if (f || nf)
            exp_q.push_back({f, nf, 27'h0, ptr});
        n_f += int'(f);
        n_nf += int'(nf);
        cyc(1'b0, 1'b0, 12'h0, 32'h0, det, msk, st);
    endtask : hit

    ////////////////////////////////////////////////////////////////////////////////
    // Any answer with no note waiting is compared against its own inverse
    always @(negedge clk)
    begin
        if (!rst && (cfg_rvalid !== 1'b0 || msg_fatal !== 1'b0 || msg_nonfatal !== 1'b0))
        begin
            obs = cfg_rvalid ? {2'b00, cfg_rdata}
                             : {msg_fatal, msg_nonfatal, 27'h0, first_fault_pointer};
            check(obs, exp_q.size() > 0 ? exp_q.pop_front() : ~obs);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd(SEV_OFFSET, 32'h0000_1340);
        rd(CAPS_OFFSET, 32'h0);
        $display("end reset values");
        wr(SEV_OFFSET, 32'hFFFF_FFFF);
        rd(SEV_OFFSET, 32'h0000_3FEE);
        wr(CAPS_OFFSET, 32'hFFFF_FFFF);
        rd(CAPS_OFFSET, 32'h0);
        rd(12'h13C, 32'h0);
        $display("end access kinds");
        for (int i = 0; i < 14; i++)
        begin
            wr(SEV_OFFSET, rnd());
            hit(14'h1 << i, 14'h1 << i, 14'h0);
            hit(14'h1 << i, 14'h0, 14'h0);
            rd(CAPS_OFFSET, {27'h0, ptr});
        end
        $display("end routing");
        repeat (2) @(negedge clk);
        check(34'(n_fatal), 34'(n_f));
        check(34'(n_nonfatal), 34'(n_nf));
        // Mid-run reset must restore defaults and clear the pointer
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        sev = SEV_RESET;
        ptr = PTR_RESET;
        n_f = 0;
        n_nf = 0;
        rd(SEV_OFFSET, 32'h0000_1340);
        rd(CAPS_OFFSET, 32'h0);
        $display("end mid-run reset");
        cfg_be = 4'h2;
        wr(SEV_OFFSET, 32'h0000_0000);
        cfg_be = 4'hF;
        rd(SEV_OFFSET, sev);
        $display("end byte enables");
        wr(SEV_OFFSET, 32'h0000_1000);
        hit(14'h0008, 14'h0, 14'h0);
        hit(14'h1004, 14'h0, 14'h0008);
        rd(CAPS_OFFSET, {27'h0, ptr});
        hit(14'h1004, 14'h0, 14'h0);
        rd(CAPS_OFFSET, {27'h0, ptr});
        repeat (3) @(negedge clk);
        check(34'(exp_q.size()), 34'h0);
        check(34'(n_fatal), 34'(n_f));
        check(34'(n_nonfatal), 34'(n_nf));
        $display("end pointer hold");
        end_sim();
    end
endmodule : sese_regs_tb
